// [design/pib_node.sv]
// Interrupt handler, acknowledge chain driver and interrupter for one board
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Driver forwards acknowledge after IACK and DSA low
// [RULE2] Idle interrupter passes acknowledge edge downstream
// [RULE3] First matching interrupter answers with vector, DTACK
// [RULE4] Line seven highest, line one lowest
// [RULE5] Simultaneous requests: highest line served first
// [RULE6] Handler owns bus before reading vector
// [RULE7] Subset handler ranks only within its subset
// [RULE8] Handler order set by bus arbitration only
// [RULE9] Low request line raises bus request
// [RULE10] On grant drive code, IACK, AS together
// [RULE11] Code is binary line number, high one
// [RULE12] Interrupter compares address code with own line
// [RULE13] Vector and DTACK wait for data strobe
// [RULE14] Latch vector on DTACK, start service
// [RULE15] Only bus owner drives IACK
// [RULE16] Current master releases bus after BCLR; node has no BCLR input and drops bus_request on leaving h_ack or on h_request falling back to h_idle
// [RULE17] Other-line interrupter forwards acknowledge edge
// [RULE18] Vector width follows configured size
// [RULE19] Release IACK, AS, strobes after vector read
module pib_node
    import pib_pkg::*;
#(
    parameter logic [6:0] HANDLED_LINES = 7'h7F,   // Lines this handler monitors
    parameter logic [2:0] IRQ_LINE      = 3'h4,    // Interrupter request line number
    parameter logic [1:0] VEC_SIZE      = 2'h1     // Interrupter vector width select
)(
    input  wire logic                  sys_clk,          // 200 MHz clock
    input  wire logic                  reset_n,          // Async reset, low active
    // Backplane inputs, active low except address and data, asynchronous
    input  wire logic [6:0]            irq_n_in,         // IRQ7..IRQ1 levels
    input  wire logic                  iack_n_in,        // Backplane IACK level
    input  wire logic                  iackin_n,         // Daisy-chain input
    input  wire logic                  as_n_in,          // Address strobe level
    input  wire logic                  dsa_n_in,         // Data strobe A level
    input  wire logic                  dtack_n_in,       // Transfer acknowledge level
    input  wire logic [CODE_WIDTH-1:0] addr_in,          // A3..A1 levels
    input  wire logic [VEC_WIDTH-1:0]  data_in,          // Data bus levels
    // Local side
    input  wire logic                  bus_granted,      // Requester owns the bus
    input  wire logic                  chain_driver_en,  // Board sits in slot 1
    input  wire logic                  local_irq,        // Local interrupt pending
    input  wire logic [VEC_WIDTH-1:0]  local_vector,     // Vector to return
    // Outputs
    output logic                       bus_request,      // Need of the data transfer bus
    output logic                       iack_n_oe,        // Drive IACK low
    output logic                       as_n_oe,          // Drive AS low
    output logic                       ds_n_oe,          // Drive data strobes low
    output logic [CODE_WIDTH-1:0]      addr_out,         // Acknowledge code
    output logic                       addr_oe,          // Drive A3..A1
    output logic                       iackout_n,        // Daisy-chain output
    output logic                       irq_n_oe,         // Pull own IRQ low
    output logic [VEC_WIDTH-1:0]       data_out,         // Vector out
    output logic                       data_oe,          // Drive data bus
    output logic                       dtack_n_oe,       // Drive DTACK low
    output logic [VEC_WIDTH-1:0]       vector_q,         // Latched vector
    output logic [CODE_WIDTH-1:0]      service_line_q,   // Line being serviced
    output logic                       service_start_q   // One-cycle service pulse
);
    initial
    begin
        if (IRQ_LINE == CODE_NONE || VEC_SIZE > VEC_SIZE_32)
            $error("pib_node: bad IRQ_LINE or VEC_SIZE");
    end

    // Three-stage synchronisers; change taken when stages two and three agree
    localparam int SYNC_W = LINE_COUNT + 5 + CODE_WIDTH;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, st_q, s1_d, s2_d, s3_d, st_d;
    logic [6:0]        irq_s;      // Filtered request levels
    logic              iack_s, iackin_s, as_s, dsa_s, dtack_s;
    logic [2:0]        addr_s;

    // Synchroniser next values
    always_comb
    begin
        s1_d = {irq_n_in, iack_n_in, iackin_n, as_n_in, dsa_n_in, dtack_n_in, addr_in};
        s2_d = s1_q;
        s3_d = s2_q;
        st_d = st_q;
        for (int i = 0; i < SYNC_W; i++)
        begin
            if (s2_q[i] == s3_q[i])
                st_d[i] = s3_q[i];
        end
    end

    // Synchroniser registers, idle high except the address
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_q <= {{(SYNC_W-CODE_WIDTH){1'b1}}, CODE_NONE};
            s2_q <= {{(SYNC_W-CODE_WIDTH){1'b1}}, CODE_NONE};
            s3_q <= {{(SYNC_W-CODE_WIDTH){1'b1}}, CODE_NONE};
            st_q <= {{(SYNC_W-CODE_WIDTH){1'b1}}, CODE_NONE};
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            st_q <= st_d;
        end
    end

    assign {irq_s, iack_s, iackin_s, as_s, dsa_s, dtack_s, addr_s} = st_q;

    // Handler: priority pick within the monitored subset
    logic [6:0] pending;   // Requests this handler may serve
    logic [2:0] top_line;  // Highest pending line number
    always_comb
    begin
        pending  = ~irq_s & HANDLED_LINES;                   // [RULE7]
        top_line = CODE_NONE;
        for (int i = 0; i < LINE_COUNT; i++)
        begin
            if (pending[i])
                top_line = 3'(i + 1);                        // [RULE4] [RULE5] [RULE11]
        end
    end

    handler_state_t   h_state_q, h_state_d;
    logic [2:0]       code_q, code_d;
    logic [VEC_WIDTH-1:0] vec_d;
    logic             start_d;
    logic [2:0]       sline_d;
    logic             h_iack, h_ds, h_req;

    // Handler next state
    always_comb
    begin
        h_state_d = h_state_q;
        code_d    = code_q;
        vec_d     = vector_q;
        start_d   = 1'b0;
        sline_d   = service_line_q;
        case (h_state_q)
            h_idle:
            begin
                if (top_line != CODE_NONE)
                    h_state_d = h_request;                   // [RULE9]
            end
            h_request:
            begin
                if (bus_granted)                             // [RULE6] [RULE8] [RULE15]
                begin
                    code_d    = top_line;                    // [RULE5]
                    h_state_d = (top_line == CODE_NONE) ? h_idle : h_ack;
                end
            end
            h_ack:
            begin
                if (!dtack_s)
                begin
                    vec_d     = data_in;                     // [RULE14]
                    sline_d   = code_q;
                    start_d   = 1'b1;
                    h_state_d = h_release;
                end
            end
            h_release:
            begin
                if (dtack_s)                                 // [RULE19]
                    h_state_d = h_recover;
            end
            h_recover:
            begin
                if (iack_s)
                    h_state_d = h_idle;
            end
            default:
                h_state_d = h_idle;
        endcase
    end

    // Handler registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            h_state_q       <= h_idle;
            code_q          <= CODE_NONE;
            vector_q        <= '0;
            service_line_q  <= CODE_NONE;
            service_start_q <= 1'b0;
        end
        else
        begin
            h_state_q       <= h_state_d;
            code_q          <= code_d;
            vector_q        <= vec_d;
            service_line_q  <= sline_d;
            service_start_q <= start_d;
        end
    end

    // Interrupter and chain driver
    logic iackin_prev_q, iackin_prev_d;  // Edge detect history
    logic fwd_q, fwd_d;                  // Forwarding acknowledge
    logic resp_q, resp_d;                // Responding
    logic own_q, own_d;                  // Own request pending
    logic match;

    always_comb
    begin
        iackin_prev_d = iackin_s;
        fwd_d  = fwd_q;
        resp_d = resp_q;
        own_d  = own_q;
        match  = own_q && (addr_s == IRQ_LINE);              // [RULE12]
        if (local_irq)
            own_d = 1'b1;
        if (chain_driver_en)
            fwd_d = !iack_s && !dsa_s;                       // [RULE1]
        else if (iackin_prev_q && !iackin_s)
        begin
            if (match)
                resp_d = 1'b1;                               // [RULE3]
            else
                fwd_d = 1'b1;                                // [RULE2] [RULE17]
        end
        if (iackin_s)
        begin
            if (!chain_driver_en)
                fwd_d = 1'b0;
            if (resp_q)
                own_d = local_irq;
            resp_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            iackin_prev_q <= 1'b1;
            fwd_q         <= 1'b0;
            resp_q        <= 1'b0;
            own_q         <= 1'b0;
        end
        else
        begin
            iackin_prev_q <= iackin_prev_d;
            fwd_q         <= fwd_d;
            resp_q        <= resp_d;
            own_q         <= own_d;
        end
    end

    // Vector width mask
    logic [VEC_WIDTH-1:0] vmask;
    always_comb
    begin
        case (VEC_SIZE)
            VEC_SIZE_8:  vmask = 32'h000000FF;               // [RULE18]
            VEC_SIZE_16: vmask = 32'h0000FFFF;
            default:     vmask = 32'hFFFFFFFF;
        endcase
    end

    assign h_iack = (h_state_q == h_ack) && bus_granted;     // [RULE10] [RULE15]
    assign h_ds   = h_iack;
    assign h_req  = (h_state_q == h_request) || (h_state_q == h_ack);

    // Output registers
    logic drive_vec;
    assign drive_vec = resp_q && !dsa_s;                     // [RULE13]
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_request <= 1'b0;
            iack_n_oe   <= 1'b0;
            as_n_oe     <= 1'b0;
            ds_n_oe     <= 1'b0;
            addr_out    <= CODE_NONE;
            addr_oe     <= 1'b0;
            iackout_n   <= 1'b1;
            irq_n_oe    <= 1'b0;
            data_out    <= '0;
            data_oe     <= 1'b0;
            dtack_n_oe  <= 1'b0;
        end
        else
        begin
            bus_request <= h_req;
            iack_n_oe   <= h_iack;
            as_n_oe     <= h_iack;
            ds_n_oe     <= h_ds;
            addr_out    <= code_q;
            addr_oe     <= h_iack;
            iackout_n   <= !fwd_q;
            irq_n_oe    <= own_q;
            data_out    <= local_vector & vmask;
            data_oe     <= drive_vec;
            dtack_n_oe  <= drive_vec && data_oe;             // [RULE13]
        end
    end

    // Checks
    property p_iack_owner;
        @(posedge sys_clk) disable iff (!reset_n)
        iack_n_oe |-> $past(bus_granted);
    endproperty
    a_iack_owner: assert property (p_iack_owner) else $error("IACK without bus"); // [RULE15]

    property p_code_with_iack;
        @(posedge sys_clk) disable iff (!reset_n)
        iack_n_oe |-> as_n_oe && addr_oe && addr_out != CODE_NONE;
    endproperty
    a_code_with_iack: assert property (p_code_with_iack) else $error("Code not with IACK"); // [RULE10]

    property p_dtack_after_data;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(dtack_n_oe) |-> $past(data_oe);
    endproperty
    a_dtack_after_data: assert property (p_dtack_after_data) else $error("DTACK before vector"); // [RULE3]

    property p_driver_fwd;
        @(posedge sys_clk) disable iff (!reset_n)
        chain_driver_en && !iack_s && !dsa_s |-> ##2 !iackout_n;
    endproperty
    a_driver_fwd: assert property (p_driver_fwd) else $error("Driver did not forward"); // [RULE1]

    property p_request;
        @(posedge sys_clk) disable iff (!reset_n)
        h_state_q == h_idle && top_line != CODE_NONE |-> ##2 bus_request;
    endproperty
    a_request: assert property (p_request) else $error("No bus request"); // [RULE9]

    property p_latch;
        @(posedge sys_clk) disable iff (!reset_n)
        h_state_q == h_ack && !dtack_s |=> service_start_q && vector_q == $past(data_in);
    endproperty
    a_latch: assert property (p_latch) else $error("Vector not latched"); // [RULE14]

    property p_top;
        @(posedge sys_clk) disable iff (!reset_n)
        h_state_q == h_request && bus_granted && top_line != CODE_NONE
        |=> code_q == $past(top_line) && pending[code_q - 3'h1];
    endproperty
    a_top: assert property (p_top) else $error("Wrong line picked"); // [RULE5]

    property p_no_resp_mismatch;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(resp_q) |-> $past(match);
    endproperty
    a_no_resp_mismatch: assert property (p_no_resp_mismatch) else $error("Bad response"); // [RULE12]

    c_service: cover property (@(posedge sys_clk) service_start_q);
    c_respond: cover property (@(posedge sys_clk) dtack_n_oe);
    c_forward: cover property (@(posedge sys_clk) !iackout_n && !chain_driver_en);
endmodule

// [design/pib_pkg.sv]
// Shared constants and types for the priority interrupt bus block
package pib_pkg;
    localparam int          LINE_COUNT   = 7;        // Request lines IRQ1..IRQ7
    localparam int          CODE_WIDTH   = 3;        // Acknowledge code width on A3..A1
    localparam logic [2:0]  CODE_NONE    = 3'h0;     // No line selected
    localparam int          VEC_WIDTH    = 32;       // Widest vector path
    localparam logic [1:0]  VEC_SIZE_8   = 2'h0;     // Byte vector on D7..D0
    localparam logic [1:0]  VEC_SIZE_16  = 2'h1;     // Half-word vector on D15..D0
    localparam logic [1:0]  VEC_SIZE_32  = 2'h2;     // Full-word vector on D31..D0
    localparam logic [6:0]  LINES_NONE   = 7'h00;    // Empty request set
    localparam logic [2:0]  SYNC_RESET   = 3'h7;     // Idle-high synchroniser contents

    // Handler sequence states
    typedef enum logic [2:0] {
        h_idle,
        h_request,
        h_ack,
        h_release,
        h_recover
    } handler_state_t;
endpackage

// [verif/pib_far_side.sv]
// Far side of the node: bus arbiter plus a remote interrupter
`timescale 1ns/1ps
module pib_far_side
    import pib_pkg::*;
#(
    parameter logic [31:0] VEC_BASE = 32'hA5C30000    // Upper bits of the remote vector
)(
    input  wire logic                 sys_clk,        // Node clock
    input  wire logic                 reset_n,        // Async reset, low active
    input  wire logic                 bus_request,    // Node wants the bus
    input  wire logic                 iack_n,         // Acknowledge level from the node
    input  wire logic                 ds_n,           // Data strobe level
    input  wire logic [2:0]           addr,           // Acknowledge code level
    input  wire logic [3:0]           delay,          // Slowness of grant and answer
    output logic                      bus_granted,    // Bus handed to the node
    output logic                      dtack_n,        // Remote acknowledge, low active
    output logic [VEC_WIDTH-1:0]      data            // Remote data bus drive
);
    logic [3:0] cnt_q;    // Cycles spent waiting
    logic       busy;     // A grant or an answer is pending
    assign busy = (bus_request & ~bus_granted) | (~iack_n & ~ds_n & dtack_n);
    // Grant once the old master let go, answer once strobes are low
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q       <= 4'h0;
            bus_granted <= 1'b0;
            dtack_n     <= 1'b1;
            data        <= '0;
        end
        else
        begin
            cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
            // Old master released after the delay, grant follows
            if (!bus_request)
                bus_granted <= 1'b0;
            else if (cnt_q >= delay)
                bus_granted <= 1'b1;
            // Released bus inverts its data each cycle, so the old vector returns every other cycle
            if (iack_n || ds_n)
            begin
                dtack_n <= 1'b1;
                data    <= ~data;
            end
            else
            begin
                data <= {VEC_BASE[31:3], addr};
                if (cnt_q >= delay)
                    dtack_n <= 1'b0;
            end
        end
    end
endmodule

// [verif/priority_interrupt_acknowledge_tb.sv]
// Self-checking bench for the interrupt handler and interrupter node
`timescale 1ns/1ps
module priority_interrupt_acknowledge_tb;
    import pib_pkg::*;
    localparam logic [31:0] VEC_BASE = 32'hA5C30000;  // Remote vector pattern
    localparam logic [6:0]  HANDLED  = 7'h77;         // Line four is left to others
    logic        sys_clk = 1'b0;       // 200 MHz clock
    logic        reset_n = 1'b0;       // Reset, low active
    logic [6:0]  irq_lvl = 7'h7F;      // Request line levels
    logic        iackin_n = 1'b1;      // Chain input level
    logic        tb_as_n = 1'b1;       // Strobe from another handler
    logic        tb_dsa_n = 1'b1;      // Data strobe from another handler
    logic [2:0]  tb_addr = 3'h0;       // Code from another handler
    logic        chain_en = 1'b0;      // Slot one driver enable
    logic        local_irq = 1'b0;     // Own request pulse
    logic [31:0] local_vector = '0;    // Own vector
    logic [3:0]  delay = 4'h0;         // Far side slowness
    integer      seed = 82;            // Random seed
    int          num_errors = 0;       // Mismatches
    int          compares = 0;         // Comparisons
    logic [34:0] expq[$];              // Expected code and vector
    logic bus_request, iack_n_oe, as_n_oe, ds_n_oe, addr_oe, iackout_n, irq_n_oe;
    logic data_oe, dtack_n_oe, service_start_q, bus_granted, far_dtack_n;
    logic [2:0]  addr_out, service_line_q;
    logic [31:0] data_out, vector_q, far_data;
    always #2.5 sys_clk = ~sys_clk;
    pib_node #(.HANDLED_LINES(HANDLED), .IRQ_LINE(3'h4), .VEC_SIZE(VEC_SIZE_16)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .irq_n_in(irq_lvl),
        .iack_n_in(~iack_n_oe & iackin_n), .iackin_n(iackin_n), .as_n_in(~as_n_oe & tb_as_n),
        .dsa_n_in(~ds_n_oe & tb_dsa_n), .dtack_n_in(~dtack_n_oe & far_dtack_n),
        .addr_in(addr_oe ? addr_out : tb_addr), .data_in(data_oe ? data_out : far_data),
        .bus_granted(bus_granted), .chain_driver_en(chain_en), .local_irq(local_irq),
        .local_vector(local_vector), .bus_request(bus_request), .iack_n_oe(iack_n_oe),
        .as_n_oe(as_n_oe), .ds_n_oe(ds_n_oe), .addr_out(addr_out), .addr_oe(addr_oe),
        .iackout_n(iackout_n), .irq_n_oe(irq_n_oe), .data_out(data_out), .data_oe(data_oe),
        .dtack_n_oe(dtack_n_oe), .vector_q(vector_q), .service_line_q(service_line_q),
        .service_start_q(service_start_q));
    pib_far_side #(.VEC_BASE(VEC_BASE)) far_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .bus_request(bus_request), .iack_n(~iack_n_oe),
        .ds_n(~ds_n_oe), .addr(addr_out), .delay(delay), .bus_granted(bus_granted),
        .dtack_n(far_dtack_n), .data(far_data));
    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Print counts and verdict, then end
    task automatic report_and_stop;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait for one output to reach a level
    task automatic wait_sig(input int sel, input logic want);
        logic s;
        for (int k = 0; k < 60; k++)
        begin
            case (sel)
                0: s = iackout_n;
                1: s = dtack_n_oe;
                2: s = irq_n_oe;
                3: s = service_start_q;
                4: s = iack_n_oe;
                default: s = bus_request;
            endcase
            if (s === want)
                return;
            @(negedge sys_clk);
        end
        num_errors++;
        report_and_stop();
    endtask
    // One handler cycle for a set of request lines
    task automatic serve(input logic [6:0] req);
        logic [2:0] code;
        code = CODE_NONE;
        for (int l = 1; l <= 7; l++)
            if (req[l-1] && HANDLED[l-1])
                code = l[2:0];
        delay = 4'($random(seed));
        irq_lvl = ~req;
        if (code == CODE_NONE)
        begin
            repeat (20) @(negedge sys_clk);
            check("bus_request", bus_request, 1'b0);
        end
        else
        begin
            expq.push_back({code, VEC_BASE[31:3], code});
            wait_sig(5, 1'b1);
            wait_sig(3, 1'b1);
        end
        irq_lvl = 7'h7F;
        wait_sig(4, 1'b0);
        wait_sig(5, 1'b0);
        repeat (8) @(negedge sys_clk);
    endtask
    // Acknowledge passing through the chain
    task automatic chain_pass(input logic [2:0] a, input logic drv);
        tb_addr = a;
        tb_as_n = 1'b0;
        iackin_n = 1'b0;
        chain_en = drv;
        if (drv)
        begin
            repeat (8) @(negedge sys_clk);
            check("iackout_n", iackout_n, 1'b1);
            tb_dsa_n = 1'b0;
        end
        wait_sig(0, 1'b0);
        check("data_oe", data_oe, 1'b0);
        iackin_n = 1'b1;
        tb_as_n = 1'b1;
        tb_dsa_n = 1'b1;
        chain_en = 1'b0;
        wait_sig(0, 1'b1);
        repeat (4) @(negedge sys_clk);
    endtask
    // Watcher: strobes during acknowledge, then vector on each service pulse
    always @(negedge sys_clk)
    begin
        if (iack_n_oe === 1'b1)
        begin
            check("as_n_oe", as_n_oe, 1'b1);
            check("ds_n_oe", ds_n_oe, 1'b1);
            check("bus_granted", bus_granted, 1'b1);
            if (expq.size() > 0 && addr_oe === 1'b1)
                check("addr_out", addr_out, expq[0][34:32]);
        end
        if (service_start_q === 1'b1)
        begin
            if (expq.size() == 0)
                check("service_start_q", 1'b1, 1'b0);
            else
            begin
                check("service_line_q", service_line_q, expq[0][34:32]);
                check("vector_q", vector_q, expq[0][31:0]);
                void'(expq.pop_front());
            end
        end
    end
    // Main sequence
    initial
    begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 7; i++)
            serve(7'h01 << i);
        for (int i = 0; i < 8; i++)
            serve(7'($random(seed)));
        chain_pass(3'h4, 1'b0);
        chain_pass(3'h2, 1'b1);
        local_vector = $random(seed);
        local_irq = 1'b1;
        @(negedge sys_clk);
        local_irq = 1'b0;
        wait_sig(2, 1'b1);
        chain_pass(3'h3, 1'b0);
        tb_addr = 3'h4;
        tb_as_n = 1'b0;
        iackin_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        check("iackout_n", iackout_n, 1'b1);
        check("dtack_n_oe", dtack_n_oe, 1'b0);
        tb_dsa_n = 1'b0;
        wait_sig(1, 1'b1);
        check("data_oe", data_oe, 1'b1);
        check("data_out", data_out, {16'h0000, local_vector[15:0]});
        tb_dsa_n = 1'b1;
        iackin_n = 1'b1;
        tb_as_n = 1'b1;
        wait_sig(1, 1'b0);
        wait_sig(2, 1'b0);
        repeat (10) @(negedge sys_clk);
        report_and_stop();
    end
endmodule
